// *** logic/tsc_regs.sv ***
/*
 * tile status and control register bank, reached by status-read and
 * status-write accesses from the tile's cores.
 * assumes all inputs are synchronous to mclk_i and that the pll output
 * and ring oscillators arrive as one-cycle tick enables.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_regs
	import tsc_pkg::*;
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_i,
	// status access port
	input wire logic ps_wr_i,
	input wire logic ps_rd_i,
	input wire logic [15:0] ps_rsrc_i,
	input wire logic [31:0] ps_wdata_i,
	output logic [31:0] ps_rdata_o,
	output logic ps_rvalid_o,
	output logic ps_wrefused_o,
	// boot straps, sampled once after reset
	input wire logic [7:0] strap_proc_num_i,
	input wire logic strap_boot_ovr_i,
	input wire logic second_processor_core_off_i,
	input wire logic strap_no_otp_poll_i,
	input wire logic strap_boot_ram_i,
	input wire logic strap_boot_jtag_i,
	input wire logic [1:0] strap_pll_mode_i,
	// otp security word
	input wire logic otp_sec_load_i,
	input wire logic [31:0] otp_sec_word_i,
	// pll and thread state
	input wire logic pll_tick_i,
	input wire logic all_paused_i,
	// ring oscillator ticks: core cell, core wire, peri cell, peri wire
	input wire logic [TSC_RO_NUM-1:0] ro_tick_i,
	// rgmii, pll divider and usb controls
	output logic rgmii_txclk_o,
	output logic [TSC_CTL_DLY_W-1:0] rgmii_txd_delay_o,
	output logic rgmii_port_en_o,
	output logic pll_div_active_o,
	output logic utmi_sel_o,
	output logic ulpi_helper_en_o,
	// security controls
	output logic global_debug_block_o,
	output logic jtag_tap_block_o,
	output logic jtag_cfg_block_o,
	output logic otp_lock_all_o,
	output logic [3:0] otp_sector_lock_o,
	output logic otp_boot_from_otp_o,
	output logic otp_redundancy_o
);
	/**********************************************/
	/* decode                                     */
	/**********************************************/
	logic [31:0] ctl_r;
	logic [31:0] boot_r;
	logic [31:0] sec_r;
	logic [31:0] ro_ctl_r;
	logic boot_done_r;
	logic [7:0] num;
	logic tag_ok;
	logic [TSC_RO_W-1:0] ro_cnt [TSC_RO_NUM];
	logic [TSC_RO_NUM-1:0] ro_run;
	logic [TSC_CTL_DIV_W-1:0] div_val;
	logic [TSC_CTL_DIV_W-1:0] div_cnt_r;
	logic [31:0] rdata_nxt;
	logic wr_ctl;
	logic wr_sec;
	logic wr_ro;
	logic wr_ok;

	assign num = ps_rsrc_i[TSC_NUM_LSB +: 8];
	// a resource id without the status tag selects nothing
	assign tag_ok = ps_rsrc_i[7:0] == TSC_PS_TAG;
	assign wr_ctl = ps_wr_i && tag_ok && num == TSC_REG_CTL;
	assign wr_sec = ps_wr_i && tag_ok && num == TSC_REG_SEC && !sec_r[TSC_SEC_LOCK];
	assign wr_ro = ps_wr_i && tag_ok && num == TSC_REG_RO_CTL;
	assign wr_ok = wr_ctl || wr_sec || wr_ro;
	assign div_val = ctl_r[TSC_CTL_DIV_LSB +: TSC_CTL_DIV_W];

	/**********************************************/
	/* writable registers                         */
	/**********************************************/
	// masking drops writes to reserved bits
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ctl_r <= TSC_CTL_RST;
		end else if (wr_ctl) begin
			ctl_r <= ps_wdata_i & TSC_CTL_WMASK;
		end
	end

	// the otp copy wins over a software write in the same cycle
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			sec_r <= TSC_SEC_RST;
		end else if (otp_sec_load_i) begin
			sec_r <= otp_sec_word_i & TSC_SEC_WMASK;
		end else if (wr_sec) begin
			sec_r <= ps_wdata_i & TSC_SEC_WMASK;
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ro_ctl_r <= TSC_RO_RST;
		end else if (wr_ro) begin
			ro_ctl_r <= ps_wdata_i & TSC_RO_WMASK;
		end
	end

	/**********************************************/
	/* boot status capture                        */
	/**********************************************/
	// straps are caught on the first edge after release, then frozen
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			boot_r <= TSC_BOOT_RST;
			boot_done_r <= 1'b0;
		end else if (!boot_done_r) begin
			boot_done_r <= 1'b1;
			boot_r <= TSC_BOOT_RST;
			boot_r[TSC_BOOT_PROC_LSB +: 8] <= strap_proc_num_i;
			boot_r[TSC_BOOT_OVR] <= strap_boot_ovr_i;
			boot_r[TSC_BOOT_CORE_OFF] <= second_processor_core_off_i;
			boot_r[TSC_BOOT_NO_POLL] <= strap_no_otp_poll_i;
			boot_r[TSC_BOOT_RAM] <= strap_boot_ram_i;
			boot_r[TSC_BOOT_JTAG] <= strap_boot_jtag_i;
			boot_r[TSC_BOOT_PLL_LSB +: 2] <= strap_pll_mode_i;
		end
	end

	/**********************************************/
	/* ring oscillator counters                   */
	/**********************************************/
	assign ro_run = {{2{ro_ctl_r[TSC_RO_PERI]}}, {2{ro_ctl_r[TSC_RO_CORE]}}};

	for (genvar g = 0; g < TSC_RO_NUM; g++) begin : g_ro
		tsc_ro_counter #(
			.W(TSC_RO_W)
		) u_cnt (
			.mclk_i(mclk_i),
			.reset_i(reset_i),
			.run_i(ro_run[g]),
			.tick_i(ro_tick_i[g]),
			.count_o(ro_cnt[g])
		);
	end

	/**********************************************/
	/* read path                                  */
	/**********************************************/
	// unknown numbers and foreign tags read as zero
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (tag_ok) begin
			case (num)
				TSC_REG_CTL: rdata_nxt = ctl_r;
				TSC_REG_BOOT: rdata_nxt = boot_r;
				TSC_REG_SEC: rdata_nxt = sec_r;
				TSC_REG_RO_CTL: rdata_nxt = ro_ctl_r;
				8'h07: rdata_nxt = {16'h0000, ro_cnt[0]};
				8'h08: rdata_nxt = {16'h0000, ro_cnt[1]};
				8'h09: rdata_nxt = {16'h0000, ro_cnt[2]};
				8'h0a: rdata_nxt = {16'h0000, ro_cnt[3]};
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ps_rdata_o <= 32'h0000_0000;
			ps_rvalid_o <= 1'b0;
		end else begin
			ps_rvalid_o <= ps_rd_i;
			if (ps_rd_i) begin
				ps_rdata_o <= rdata_nxt;
			end
		end
	end

	// read-only, locked or unmapped targets flag the write as refused
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			ps_wrefused_o <= 1'b0;
		end else begin
			ps_wrefused_o <= ps_wr_i && !wr_ok;
		end
	end

	/**********************************************/
	/* rgmii transmit clock                       */
	/**********************************************/
	// counter wraps after the divider value, so the period is value + 1
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			div_cnt_r <= '0;
		end else if (pll_tick_i) begin
			if (div_cnt_r >= div_val) begin
				div_cnt_r <= '0;
			end else begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end

	// with a value of zero both compares hit; rising wins, clock stays high
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rgmii_txclk_o <= 1'b0;
		end else if (pll_tick_i) begin
			if (div_cnt_r == div_val) begin
				rgmii_txclk_o <= 1'b1;
			end else if (div_cnt_r == (div_val >> 1)) begin
				rgmii_txclk_o <= 1'b0;
			end
		end
	end

	/**********************************************/
	/* control outputs                            */
	/**********************************************/
	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			rgmii_txd_delay_o <= '0;
			rgmii_port_en_o <= 1'b0;
			pll_div_active_o <= 1'b0;
			utmi_sel_o <= 1'b0;
			ulpi_helper_en_o <= 1'b0;
		end else begin
			rgmii_txd_delay_o <= ctl_r[TSC_CTL_DLY_LSB +: TSC_CTL_DLY_W];
			rgmii_port_en_o <= ctl_r[TSC_CTL_RGMII_EN];
			pll_div_active_o <= ctl_r[TSC_CTL_DIV_EN] &&
				(!ctl_r[TSC_CTL_DYN] || all_paused_i);
			utmi_sel_o <= ctl_r[TSC_CTL_UTMI];
			ulpi_helper_en_o <= ctl_r[TSC_CTL_ULPI];
		end
	end

	always_ff @(posedge mclk_i or posedge reset_i) begin
		if (reset_i) begin
			global_debug_block_o <= 1'b0;
			jtag_tap_block_o <= 1'b0;
			jtag_cfg_block_o <= 1'b0;
			otp_lock_all_o <= 1'b0;
			otp_sector_lock_o <= 4'h0;
			otp_boot_from_otp_o <= 1'b0;
			otp_redundancy_o <= 1'b0;
		end else begin
			global_debug_block_o <= sec_r[TSC_SEC_GDBG];
			jtag_tap_block_o <= sec_r[TSC_SEC_TAP];
			jtag_cfg_block_o <= sec_r[TSC_SEC_JCFG];
			otp_lock_all_o <= sec_r[TSC_SEC_OTP_ALL];
			otp_sector_lock_o <= sec_r[TSC_SEC_SECT_LSB +: 4];
			otp_boot_from_otp_o <= sec_r[TSC_SEC_OTP_BOOT];
			otp_redundancy_o <= sec_r[TSC_SEC_RED];
		end
	end

	/**********************************************/
	/* checks                                     */
	/**********************************************/
	sequence s_ctl_write;
		ps_wr_i && tag_ok && num == TSC_REG_CTL;
	endsequence

	sequence s_locked_sec_write;
		ps_wr_i && tag_ok && num == TSC_REG_SEC && sec_r[TSC_SEC_LOCK] && !otp_sec_load_i;
	endsequence

	property p_delay_out;
		@(posedge mclk_i) disable iff (reset_i)
		s_ctl_write |-> ##2 rgmii_txd_delay_o == $past(ps_wdata_i[TSC_CTL_DLY_LSB +: TSC_CTL_DLY_W], 2);
	endproperty
	a_delay_out: assert property (p_delay_out) else $error("tx delay not applied");

	property p_txclk_rise;
		@(posedge mclk_i) disable iff (reset_i)
		pll_tick_i && div_cnt_r == div_val |=> rgmii_txclk_o;
	endproperty
	a_txclk_rise: assert property (p_txclk_rise) else $error("tx clock did not rise");

	property p_txclk_fall;
		@(posedge mclk_i) disable iff (reset_i)
		pll_tick_i && div_cnt_r != div_val && div_cnt_r == (div_val >> 1) |=> !rgmii_txclk_o;
	endproperty
	a_txclk_fall: assert property (p_txclk_fall) else $error("tx clock did not fall");

	property p_port_en;
		@(posedge mclk_i) disable iff (reset_i)
		s_ctl_write |-> ##2 rgmii_port_en_o == $past(ps_wdata_i[TSC_CTL_RGMII_EN], 2);
	endproperty
	a_port_en: assert property (p_port_en) else $error("port enable wrong");

	property p_dyn_div;
		@(posedge mclk_i) disable iff (reset_i)
		ctl_r[TSC_CTL_DIV_EN] && ctl_r[TSC_CTL_DYN] && !all_paused_i |=> !pll_div_active_o;
	endproperty
	a_dyn_div: assert property (p_dyn_div) else $error("divider active while running");

	property p_static_div;
		@(posedge mclk_i) disable iff (reset_i)
		ctl_r[TSC_CTL_DIV_EN] && !ctl_r[TSC_CTL_DYN] |=> pll_div_active_o;
	endproperty
	a_static_div: assert property (p_static_div) else $error("static divider idle");

	property p_sec_lock;
		@(posedge mclk_i) disable iff (reset_i)
		s_locked_sec_write |=> $stable(sec_r) ##0 ps_wrefused_o;
	endproperty
	a_sec_lock: assert property (p_sec_lock) else $error("locked register written");

	property p_otp_copy;
		@(posedge mclk_i) disable iff (reset_i)
		otp_sec_load_i |=> sec_r == ($past(otp_sec_word_i) & TSC_SEC_WMASK);
	endproperty
	a_otp_copy: assert property (p_otp_copy) else $error("otp word not copied");

	property p_boot_hold;
		@(posedge mclk_i) disable iff (reset_i)
		boot_done_r |=> $stable(boot_r);
	endproperty
	a_boot_hold: assert property (p_boot_hold) else $error("boot status changed");

	property p_rsvd_zero;
		@(posedge mclk_i) disable iff (reset_i)
		ps_rd_i && tag_ok && num == TSC_REG_CTL |=> ps_rvalid_o && ps_rdata_o[31:26] == 6'h00;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits not zero");

	property p_bad_tag;
		@(posedge mclk_i) disable iff (reset_i)
		ps_rd_i && !tag_ok |=> ps_rdata_o == 32'h0000_0000;
	endproperty
	a_bad_tag: assert property (p_bad_tag) else $error("untagged read returned data");

	property p_ro_stop;
		@(posedge mclk_i) disable iff (reset_i)
		wr_ro && !ps_wdata_i[TSC_RO_CORE] |=> ##1 $stable(ro_cnt[0]) && $stable(ro_cnt[1]);
	endproperty
	a_ro_stop: assert property (p_ro_stop) else $error("core counters not stopped");
endmodule
`default_nettype wire

// *** shared/tsc_pkg.sv ***
/*
 * constants for the tile status and control register bank.
 * assumes register numbers are carried in bits 15:8 of the resource id.
 */
`default_nettype none
package tsc_pkg;
	// resource id low byte that marks a processor status access
	localparam logic [7:0] TSC_PS_TAG = 8'h0c;
	localparam int TSC_NUM_LSB = 8;
	// register numbers
	localparam logic [7:0] TSC_REG_CTL = 8'h02;
	localparam logic [7:0] TSC_REG_BOOT = 8'h03;
	localparam logic [7:0] TSC_REG_SEC = 8'h05;
	localparam logic [7:0] TSC_REG_RO_CTL = 8'h06;
	localparam logic [7:0] TSC_REG_RO_VAL0 = 8'h07;
	// tile_feature_control fields
	localparam int TSC_CTL_DLY_LSB = 18;
	localparam int TSC_CTL_DLY_W = 8;
	localparam int TSC_CTL_DIV_LSB = 9;
	localparam int TSC_CTL_DIV_W = 9;
	localparam int TSC_CTL_RGMII_EN = 8;
	localparam int TSC_CTL_DYN = 5;
	localparam int TSC_CTL_DIV_EN = 4;
	localparam int TSC_CTL_UTMI = 2;
	localparam int TSC_CTL_ULPI = 1;
	localparam logic [31:0] TSC_CTL_WMASK = 32'h03ff_ff36;
	localparam logic [31:0] TSC_CTL_RST = 32'h0000_0000;
	// tile_boot_status fields
	localparam int TSC_BOOT_PROC_LSB = 16;
	localparam int TSC_BOOT_OVR = 8;
	localparam int TSC_BOOT_CORE_OFF = 5;
	localparam int TSC_BOOT_NO_POLL = 4;
	localparam int TSC_BOOT_RAM = 3;
	localparam int TSC_BOOT_JTAG = 2;
	localparam int TSC_BOOT_PLL_LSB = 0;
	localparam logic [31:0] TSC_BOOT_RST = 32'h0000_0000;
	// security_configuration fields
	localparam int TSC_SEC_LOCK = 31;
	localparam int TSC_SEC_GDBG = 14;
	localparam int TSC_SEC_OTP_ALL = 12;
	localparam int TSC_SEC_SECT_LSB = 8;
	localparam int TSC_SEC_RED = 7;
	localparam int TSC_SEC_OTP_BOOT = 5;
	localparam int TSC_SEC_JCFG = 4;
	localparam int TSC_SEC_TAP = 0;
	localparam logic [31:0] TSC_SEC_WMASK = 32'h8000_5fb1;
	localparam logic [31:0] TSC_SEC_RST = 32'h0000_0000;
	// ring_oscillator_control fields
	localparam int TSC_RO_CORE = 1;
	localparam int TSC_RO_PERI = 0;
	localparam logic [31:0] TSC_RO_WMASK = 32'h0000_0003;
	localparam logic [31:0] TSC_RO_RST = 32'h0000_0000;
	localparam int TSC_RO_W = 16;
	localparam int TSC_RO_NUM = 4;
endpackage
`default_nettype wire

// *** logic/tsc_ro_counter.sv ***
/*
 * one ring oscillator counter.
 * assumes the oscillator arrives as a tick already synchronous to mclk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_ro_counter #(
	parameter int W = 16
) (
	// clock and reset (reset only gates the checks)
	input wire logic mclk_i,
	input wire logic reset_i,
	// oscillator
	input wire logic run_i,
	input wire logic tick_i,
	// count
	output logic [W-1:0] count_o
);
	if (W < 1 || W > 32) begin : g_chk
		$error("tsc_ro_counter: W must be 1..32");
	end

	// no reset: the count must survive a system reset; the start value only keeps
	// simulation free of unknowns, real cells power up holding any count
	logic [W-1:0] count_r = '0;

	assign count_o = count_r;

	always_ff @(posedge mclk_i) begin
		if (run_i && tick_i) begin
			count_r <= count_r + 1'b1;
		end
	end

	property p_ro_hold;
		@(posedge mclk_i) disable iff (reset_i)
		!run_i [*2] |=> $stable(count_o);
	endproperty
	a_ro_hold: assert property (p_ro_hold) else $error("ro count moved while stopped");

	property p_ro_step;
		@(posedge mclk_i) disable iff (reset_i)
		run_i && tick_i |=> count_o == W'($past(count_o) + 1'b1);
	endproperty
	a_ro_step: assert property (p_ro_step) else $error("ro count missed a tick");
endmodule
`default_nettype wire

// *** dv/tsc_regs_tb_top.sv ***
/*
 * self-checking bench for the tile status and control register bank.
 * assumes one 125 MHz clock, inputs driven at the falling edge, and
 * ring oscillator and pll ticks given as one-cycle enables.
 */
`timescale 1ns/1ps
`default_nettype none
module tsc_regs_tb_top
	import tsc_pkg::*;
;
	logic mclk, reset, ps_wr, ps_rd, otp_load, pll_tick, all_paused;
	logic [15:0] ps_rsrc;
	logic [31:0] ps_wdata, ps_rdata, otp_word, rd_val, v;
	logic ps_rvalid, ps_wrefused, s_ovr, s_off, s_nopoll, s_ram, s_jtag;
	logic [7:0] s_proc, txd_dly;
	logic [1:0] s_pll;
	logic [3:0] ro_tick, sect;
	logic txclk, port_en, div_act, utmi, ulpi, gdbg, tap, jcfg, lock_all, boot_otp, red;
	logic prev;
	logic [15:0] base [TSC_RO_NUM];
	integer failures = 0;
	integer samples_checked = 0;
	integer seed = 78;
	int n, hi, rises;

	tsc_regs tsc_regs_i (.mclk_i(mclk), .reset_i(reset), .ps_wr_i(ps_wr), .ps_rd_i(ps_rd),
		.ps_rsrc_i(ps_rsrc), .ps_wdata_i(ps_wdata), .ps_rdata_o(ps_rdata),
		.ps_rvalid_o(ps_rvalid), .ps_wrefused_o(ps_wrefused), .strap_proc_num_i(s_proc),
		.strap_boot_ovr_i(s_ovr), .second_processor_core_off_i(s_off),
		.strap_no_otp_poll_i(s_nopoll), .strap_boot_ram_i(s_ram), .strap_boot_jtag_i(s_jtag),
		.strap_pll_mode_i(s_pll), .otp_sec_load_i(otp_load), .otp_sec_word_i(otp_word),
		.pll_tick_i(pll_tick), .all_paused_i(all_paused), .ro_tick_i(ro_tick),
		.rgmii_txclk_o(txclk), .rgmii_txd_delay_o(txd_dly), .rgmii_port_en_o(port_en),
		.pll_div_active_o(div_act), .utmi_sel_o(utmi), .ulpi_helper_en_o(ulpi),
		.global_debug_block_o(gdbg), .jtag_tap_block_o(tap), .jtag_cfg_block_o(jcfg),
		.otp_lock_all_o(lock_all), .otp_sector_lock_o(sect), .otp_boot_from_otp_o(boot_otp),
		.otp_redundancy_o(red));

	initial begin
		mclk = 1'h0;
		forever #4 mclk = ~mclk;
	end

	/****************************************
	 * shared tasks
	 ****************************************/
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rd(input logic [7:0] num, input logic [7:0] tag = TSC_PS_TAG);
		@(negedge mclk);
		ps_rd = 1'h1;
		ps_rsrc = {num, tag};
		@(negedge mclk);
		ps_rd = 1'h0;
		chk("read valid", 32'h1, ps_rvalid);
		rd_val = ps_rdata;
	endtask

	task automatic wr(input logic [7:0] num, input logic [31:0] d, input logic refused,
		input logic [7:0] tag = TSC_PS_TAG);
		@(negedge mclk);
		ps_wr = 1'h1;
		ps_rsrc = {num, tag};
		ps_wdata = d;
		@(negedge mclk);
		ps_wr = 1'h0;
		chk("write refused flag", refused, ps_wrefused);
	endtask

	// boot word as the straps place it
	function automatic logic [31:0] boot_exp();
		return {8'h00, s_proc, 7'h00, s_ovr, 2'h0, s_off, s_nopoll, s_ram, s_jtag, s_pll};
	endfunction

	task automatic do_reset;
		reset = 1'h1;
		repeat (6) @(negedge mclk);
		reset = 1'h0;
	endtask

	/****************************************
	 * main sequence
	 ****************************************/
	initial begin
		reset = 1'h1;
		{ps_wr, ps_rd, otp_load, pll_tick, all_paused} = 5'h00;
		ps_rsrc = 16'h0000;
		ps_wdata = 32'h0;
		otp_word = 32'h0;
		ro_tick = 4'h0;
		v = $random(seed);
		{s_proc, s_ovr, s_off, s_nopoll, s_ram, s_jtag, s_pll} = v[14:0];
		do_reset();
		chk("outputs at reset", 32'h0, {txclk, txd_dly, port_en, div_act, utmi, ulpi, gdbg,
			tap, jcfg, lock_all, sect, boot_otp, red});
		rd(TSC_REG_BOOT);
		chk("boot status", boot_exp(), rd_val);
		v = boot_exp();
		// flip every strap so that a fresh capture would show
		{s_proc, s_ovr, s_off, s_nopoll, s_ram, s_jtag, s_pll} =
			~{s_proc, s_ovr, s_off, s_nopoll, s_ram, s_jtag, s_pll};
		wr(TSC_REG_BOOT, 32'hffff_ffff, 1'h1);
		rd(TSC_REG_BOOT);
		chk("boot status held", v, rd_val);
		$display("test boot done");

		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 32'h0000_0030 : (i == 1) ? 32'hffff_ffff :
				(i == 2) ? 32'h0000_0010 : $random(seed);
			all_paused = (i < 2) ? i[0] : 1'($random(seed));
			wr(TSC_REG_CTL, v, 1'h0);
			@(negedge mclk);
			chk("tx delay", v[25:18], txd_dly);
			chk("rgmii ports", v[8], port_en);
			chk("divider active", v[4] & (~v[5] | all_paused), div_act);
			chk("utmi select", v[2], utmi);
			chk("ulpi helper", v[1], ulpi);
			rd(TSC_REG_CTL);
			chk("control readback", v & TSC_CTL_WMASK, rd_val);
		end
		$display("test control done");

		// 60 ticks hold a whole number of periods for ratios 4, 5 and 6
		for (int d = 3; d <= 5; d++) begin
			wr(TSC_REG_CTL, d << TSC_CTL_DIV_LSB, 1'h0);
			pll_tick = 1'h1;
			repeat (12) @(negedge mclk);
			prev = txclk;
			hi = 0;
			rises = 0;
			repeat (60) begin
				@(negedge mclk);
				hi += (txclk === 1'h1);
				rises += (txclk === 1'h1 && prev === 1'h0);
				prev = txclk;
			end
			pll_tick = 1'h0;
			chk("tx clock rises", 60 / (d + 1), rises);
			chk("tx clock high ticks", (60 / (d + 1)) * (1 + (d >> 1)), hi);
		end
		$display("test tx clock done");

		v = $random(seed) & 32'h7fff_ffff;
		wr(TSC_REG_SEC, v, 1'h0);
		@(negedge mclk);
		chk("security outputs", {v[14], v[0], v[12], v[11:8], v[5], v[7], v[4]},
			{gdbg, tap, lock_all, sect, boot_otp, red, jcfg});
		wr(TSC_REG_SEC, v | 32'h8000_0000, 1'h0);
		wr(TSC_REG_SEC, 32'h0, 1'h1);
		rd(TSC_REG_SEC);
		chk("locked security", (v | 32'h8000_0000) & TSC_SEC_WMASK, rd_val);
		// the otp copy still lands while software is locked out
		otp_word = $random(seed);
		@(negedge mclk);
		otp_load = 1'h1;
		@(negedge mclk);
		otp_load = 1'h0;
		rd(TSC_REG_SEC);
		chk("otp security copy", otp_word & TSC_SEC_WMASK, rd_val);
		$display("test security done");

		for (int m = 1; m <= 2; m++) begin
			wr(TSC_REG_RO_CTL, m, 1'h0);
			rd(TSC_REG_RO_CTL);
			chk("oscillator control", m, rd_val);
			for (int k = 0; k < TSC_RO_NUM; k++) begin
				rd(8'(TSC_REG_RO_VAL0 + k));
				base[k] = rd_val[15:0];
			end
			n = 1 + ($random(seed) & 31);
			ro_tick = 4'hf;
			repeat (n) @(negedge mclk);
			ro_tick = 4'h0;
			wr(TSC_REG_RO_CTL, 32'h0, 1'h0);
			repeat (10) @(negedge mclk);
			ro_tick = 4'hf;
			for (int k = 0; k < TSC_RO_NUM; k++) begin
				rd(8'(TSC_REG_RO_VAL0 + k));
				chk("counter upper bits", 32'h0, rd_val[31:16]);
				// counters are never reset, so only the change over the run is checked
				chk("counter delta", (m[1 - k / 2] ? n : 0), 16'(rd_val[15:0] - base[k]));
				base[k] = rd_val[15:0];
			end
			ro_tick = 4'h0;
			do_reset();
			rd(TSC_REG_CTL);
			chk("control after reset", 32'h0, rd_val);
			for (int k = 0; k < TSC_RO_NUM; k++) begin
				rd(8'(TSC_REG_RO_VAL0 + k));
				chk("counter across reset", base[k], rd_val[15:0]);
			end
		end
		$display("test ring oscillators done");

		rd(8'h04);
		chk("unmapped read", 32'h0, rd_val);
		rd(TSC_REG_CTL, 8'h0d);
		chk("bad tag read", 32'h0, rd_val);
		wr(8'h04, 32'hffff_ffff, 1'h1);
		wr(TSC_REG_CTL, 32'hffff_ffff, 1'h1, 8'h0d);
		wr(TSC_REG_RO_VAL0, 32'hffff_ffff, 1'h1);
		rd(TSC_REG_CTL);
		chk("control untouched", 32'h0, rd_val);
		$display("test refusals done");
		conclude();
	end

	// the sequence needs fewer than 500 cycles; this leaves wide margin
	initial begin
		#(30000 * 8);
		failures++;
		conclude();
	end
endmodule
`default_nettype wire
